// ===== sim/pci_master_window_cfg_proxy_test.sv
// Self-checking bench for the PCI master window bridge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    num_errors++; $display("Error at %0t: got %h expected %h", \
    $time, (a), (e)); end end
module pci_master_window_cfg_proxy_test;
    import pcimw_pkg::*;
    typedef struct packed {logic [31:0] a; logic [31:0] w;
        logic [31:0] e;} pcimw_row_type;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic be_req = 1'b0, be_write = 1'b1, be_wpush = 1'b0;
    logic pci_clk = 1'b0, no_claim = 1'b0;
    logic hreadyout, hresp, be_ack, be_done;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, be_addr = 32'h0;
    logic [31:0] be_wdata = 32'h0, rd_word = 32'h0, rd;
    logic [31:0] hrdata, be_rdata, seen_addr, seen_data;
    logic [1:0] htrans = 2'h0, be_src = 2'h1, waits = 2'h0;
    logic [3:0] seen_cmd, seen_be_n;
    pcimw_pin_in_type pin_in;
    pcimw_pin_out_type pin_out;
    int num_errors = 0, checks_done = 0, cycles = 0, i, n;
    pcimw_row_type rows [5] = '{
        '{32'h000, 32'hffff_ffff, 32'hff80_0000},
        '{32'h07c, 32'h1234_5678, 32'h1200_0000},
        '{32'h004, 32'h1280_0000, 32'h1280_0000},
        '{32'h104, 32'ha5a5_a5a5, 32'ha5a5_a5a5},
        '{32'h200, 32'hffff_ffff, 32'h0000_0000}};
    pcimw_bridge pcimw_bridge_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .be_req(be_req), .be_addr(be_addr), .be_write(be_write),
        .be_len(5'h1), .be_src(be_src), .be_ack(be_ack),
        .be_done(be_done), .be_wpush(be_wpush), .be_wdata(be_wdata),
        .be_ridx(4'h0), .be_rdata(be_rdata), .pci_clk(pci_clk),
        .pin_in(pin_in), .pin_out(pin_out));
    pcimw_agent pcimw_agent_inst (.pci_clk(pci_clk), .pin_out(pin_out),
        .waits(waits), .no_claim(no_claim), .rd_word(rd_word),
        .pin_in(pin_in), .seen_addr(seen_addr), .seen_cmd(seen_cmd),
        .seen_data(seen_data), .seen_be_n(seen_be_n));
    // Clocks: the link clock runs free at 160 ns.
    initial forever #2 hclk = ~hclk;
    initial forever #80 pci_clk = ~pci_clk;
    // A hang is cut short well past the longest expected run.
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One single AHB-Lite word transfer; waits on hready both phases.
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Polls the command register; a bounded count keeps a stuck bit visible.
    task automatic wait_ready;
        for (n = 0; n < 500; n++) begin
            ahb(1'b0, 32'h100, 32'h0);
            if (rd[31] === 1'b1) break;
        end
    endtask
    task automatic wait_ev(input logic ack);
        for (n = 0; n < 4000; n++) begin
            if ((ack ? be_ack : be_done) === 1'b1) break;
            @(posedge hclk);
        end
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            ahb(1'b1, rows[i].a, rows[i].w);
            ahb(1'b0, rows[i].a, 32'h0);
            `CHK(rd, rows[i].e)
        end
        // Config write, type 1 address, sparse byte enables, two waits.
        waits <= 2'h2;
        wait_ready(); // ready seen before data, address, command
        ahb(1'b1, 32'h104, 32'hdead_beef);
        ahb(1'b1, 32'h108, 32'h0000_0801);
        ahb(1'b1, 32'h100, 32'h0000_0050);
        ahb(1'b0, 32'h100, 32'h0);
        `CHK(rd[31], 1'b0)
        wait_ready();
        `CHK(rd[31], 1'b1)
        `CHK(seen_cmd, PCMD_CFG_WR)
        `CHK(seen_addr, 32'h0000_0801)
        `CHK(seen_data, 32'hdead_beef)
        `CHK(seen_be_n, 4'ha)
        // Config read returns the target's word into the data register.
        waits <= 2'h0;
        rd_word <= 32'h1357_9bdf;
        ahb(1'b1, 32'h108, 32'h0000_0800);
        ahb(1'b1, 32'h100, 32'h0000_00f1);
        wait_ready();
        ahb(1'b0, 32'h104, 32'h0);
        `CHK(rd, 32'h1357_9bdf)
        `CHK(seen_cmd, PCMD_CFG_RD)
        // Memory write through window 1 with junk in the top nibble.
        be_wpush <= 1'b1;
        be_wdata <= 32'h0bad_cafe;
        @(posedge hclk);
        be_wpush <= 1'b0;
        be_addr <= 32'h5080_abcd;
        be_req <= 1'b1;
        wait_ev(1'b1);
        be_req <= 1'b0;
        wait_ev(1'b0);
        `CHK(be_done, 1'b1)
        `CHK(seen_addr, 32'h1280_abcd)
        `CHK(seen_cmd, PCMD_MEM_WR)
        `CHK(seen_data, 32'h0bad_cafe)
        // Controller 0 must never be acknowledged.
        @(posedge hclk);
        be_src <= 2'h0;
        be_req <= 1'b1;
        i = 0;
        repeat (8) begin
            @(posedge hclk);
            if (be_ack === 1'b1) i++;
        end
        be_req <= 1'b0;
        `CHK(i, 0)
        ahb(1'b0, 32'h110, 32'h0);
        `CHK(rd[ST_REFUSED], 1'b1)
        // Memory read of one word lands in the read buffer.
        be_src <= 2'h2;
        be_write <= 1'b0;
        be_req <= 1'b1;
        wait_ev(1'b1);
        be_req <= 1'b0;
        wait_ev(1'b0);
        `CHK(be_rdata, rd_word)
        `CHK(seen_cmd, PCMD_MEM_RD)
        // Nobody claims the cycle: master abort still ends with ready.
        no_claim <= 1'b1;
        ahb(1'b1, 32'h110, 32'h0000_00ff);
        ahb(1'b1, 32'h100, 32'h0000_0052);
        wait_ready();
        `CHK(rd[31], 1'b1)
        ahb(1'b0, 32'h110, 32'h0);
        `CHK(rd[ST_MABORT], 1'b1)
        `CHK(seen_cmd, PCMD_IO_WR)
        // Reset in mid-run restores the documented values.
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 32'h004, 32'h0);
        `CHK(rd, 32'h0)
        ahb(1'b0, 32'h100, 32'h0);
        `CHK(rd, CMD_RESET)
        conclude();
    end
endmodule
`default_nettype wire

// ===== sim/pcimw_agent.sv
// Behavioural PCI arbiter and single target facing the bridge.
`timescale 1ns/1ps
`default_nettype none
module pcimw_agent (
    input wire logic pci_clk,
    input wire pcimw_pkg::pcimw_pin_out_type pin_out,
    input wire logic [1:0] waits,
    input wire logic no_claim,
    input wire logic [31:0] rd_word,
    output pcimw_pkg::pcimw_pin_in_type pin_in,
    output logic [31:0] seen_addr,
    output logic [3:0] seen_cmd,
    output logic [31:0] seen_data,
    output logic [3:0] seen_be_n
);
    import pcimw_pkg::*;
    logic gnt_n = 1'b1;
    logic trdy_n = 1'b1;
    logic devsel_n = 1'b1;
    logic [1:0] cnt = 2'h0;
    logic [31:0] t_ad = 32'h0;
    // Stop, parity and system error lines rest at their pull-up level.
    assign pin_in = {gnt_n, trdy_n, 1'b1, devsel_n, 2'h3,
                     pin_out.ad_oe ? pin_out.ad : t_ad};
    // address capture, target waits
    // Released AD toggles so a stale value can never pass for read data.
    always @(posedge pci_clk) begin
        gnt_n <= pin_out.req_n;
        t_ad <= ~t_ad;
        if (pin_out.frame_oe && !pin_out.frame_n && pin_out.irdy_n) begin
            seen_addr <= pin_out.ad;
            seen_cmd <= pin_out.cbe_n;
            devsel_n <= no_claim;
            cnt <= waits;
        end else if (!trdy_n) begin
            trdy_n <= 1'b1;
            devsel_n <= 1'b1;
        end else if (!devsel_n && !pin_out.irdy_n) begin
            if (cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
            end else begin
                trdy_n <= 1'b0;
                seen_data <= pin_out.ad;
                seen_be_n <= pin_out.cbe_n;
                if (!seen_cmd[0]) begin
                    t_ad <= rd_word;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/pcimw_bridge.sv
// PCI master: window translation, proxy config/IO cycles, AHB registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RULE1) Thirty-two window registers, one per window.
// (RULE2) Windows are ascending contiguous 8MB slices.
// (RULE3) Top four local address bits ignored.
// (RULE4) Next five bits select the window.
// (RULE5) PCI address: upper field plus bits 22:0.
// (RULE6) Upper field bits 31:23, read/write, reset zero.
// (RULE7) Bits 22:0 read zero, writes ignored.
// (RULE8) Only controllers 1, 2, 3 reach PCI memory.
// (RULE9) Memory from back end, config/IO from proxy.
// (RULE10) Basic or automatic burst command choice.
// (RULE11) Separate sixteen-word read and write buffers.
// (RULE12) Config address 31:2 selects; low bits type.
// (RULE13) Byte enable n enables byte n.
// (RULE14) Software: ready, data, address, then command.
// (RULE15) Request after command; frame, address, 0xB.
// (RULE16) Next cycle: irdy, frame off, write data.
// (RULE17) No own waits; stretch while trdy inactive.
// (RULE18) Watch and handle all bus exceptions.
// (RULE19) Set ready when config write finishes.
// (RULE20) Config read: 0xA, data to data register.
// (RULE21) Ready cleared from command until end.
// (RULE22) Exceptions still end with ready set.
module pcimw_bridge (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic be_req,
    input wire logic [31:0] be_addr,
    input wire logic be_write,
    input wire logic [4:0] be_len,
    input wire logic [1:0] be_src,
    output logic be_ack,
    output logic be_done,
    input wire logic be_wpush,
    input wire logic [31:0] be_wdata,
    input wire logic [3:0] be_ridx,
    output logic [31:0] be_rdata,
    input wire logic pci_clk,
    input wire pcimw_pkg::pcimw_pin_in_type pin_in,
    output pcimw_pkg::pcimw_pin_out_type pin_out
);
    import pcimw_pkg::*;

    typedef enum {S_IDLE, S_REQ, S_ADDR, S_DATA, S_TURN} pcimw_st_type;

    logic [UPPER_W-1:0] win_ff [WIN_NUM];
    logic [31:0] cmd_ff, data_ff, addr_ff, ctrl_ff, stat_ff;
    logic [31:0] wbuf [BUF_DEPTH];
    logic [31:0] rbuf [BUF_DEPTH];
    logic [3:0] wptr_ff;
    logic clk_s1_ff, clk_s2_ff, clk_s3_ff;
    pcimw_pin_in_type in_s1_ff, in_s2_ff;
    pcimw_st_type st_ff;
    pcimw_pin_out_type po_ff;
    logic mem_ff, rd_ff, devsel_seen_ff;
    logic [4:0] len_ff, idx_ff;
    logic [31:0] paddr_ff;
    logic [3:0] pcmd_ff, dcnt_ff;
    logic [7:0] lat_ff;
    logic [31:0] aph_addr_ff;
    logic aph_wr_ff, aph_rd_ff, rd_wait_ff;
    logic [31:0] hrdata_ff;
    logic pe, cmd_wr, stat_wr, proxy_go, mem_go, xfer, last, fin;
    logic [6:0] err_set;

    // Word-aligned register offset inside the 4KB block.
    function automatic logic [11:0] reg_off(input logic [31:0] a);
        reg_off = {a[11:2], 2'b00};
    endfunction

    // Read view of every register; reserved window bits come back as zero, reserved command and control bits as written.
    function automatic logic [31:0] reg_view(input logic [11:0] o);
        reg_view = 32'h0;
        if (o < OFF_WIN0 + 12'(WIN_NUM * 4)) begin
            // (RULE7) reserved bits zero
            reg_view[31:UPPER_LSB] = win_ff[o[6:2]];
        end else begin
            unique case (o)
                OFF_CMD: reg_view = cmd_ff;
                OFF_DATA: reg_view = data_ff;
                OFF_ADDR: reg_view = addr_ff;
                OFF_CTRL: reg_view = ctrl_ff;
                OFF_STAT: reg_view = stat_ff;
                default: reg_view = 32'h0;
            endcase
        end
    endfunction

    // Bus address phase capture; reads take one wait state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_wr_ff <= 1'b0;
            aph_rd_ff <= 1'b0;
            aph_addr_ff <= 32'h0;
        end else if (hready) begin
            aph_wr_ff <= hsel && htrans[1] && hwrite;
            aph_rd_ff <= hsel && htrans[1] && !hwrite;
            aph_addr_ff <= haddr;
        end
    end

    // Read data is latched in the wait cycle so it is always a flop.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait_ff <= 1'b0;
            hrdata_ff <= 32'h0;
        end else begin
            rd_wait_ff <= aph_rd_ff && !rd_wait_ff;
            if (aph_rd_ff && !rd_wait_ff) begin
                hrdata_ff <= reg_view(reg_off(aph_addr_ff));
            end
        end
    end

    assign hreadyout = !(aph_rd_ff && !rd_wait_ff);
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign cmd_wr = aph_wr_ff && reg_off(aph_addr_ff) == OFF_CMD;
    assign stat_wr = aph_wr_ff && reg_off(aph_addr_ff) == OFF_STAT;
    // A command write while a transaction runs is ignored.
    // (RULE9) proxy start only by command write
    assign proxy_go = cmd_wr && cmd_ff[CMD_READY_BIT] && st_ff == S_IDLE;

    // Window registers, one per 8MB slice.
    // (RULE1) thirty-two window registers
    generate
        for (genvar w = 0; w < WIN_NUM; w++) begin : g_win
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    win_ff[w] <= '0;
                end else if (aph_wr_ff &&
                        reg_off(aph_addr_ff) == OFF_WIN0 + 12'(w * 4)) begin
                    // (RULE6) upper field write
                    win_ff[w] <= hwdata[31:UPPER_LSB];
                end
            end
        end
    endgenerate

    // Proxy registers and control; hardware owns the ready bit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_ff <= CMD_RESET;
            addr_ff <= 32'h0;
            ctrl_ff <= CTRL_RESET;
        end else begin
            if (aph_wr_ff && reg_off(aph_addr_ff) == OFF_ADDR) begin
                addr_ff <= hwdata;
            end
            if (aph_wr_ff && reg_off(aph_addr_ff) == OFF_CTRL) begin
                ctrl_ff <= hwdata;
            end
            if (proxy_go) begin
                // (RULE21) ready cleared on start
                cmd_ff <= {1'b0, hwdata[30:0]};
            end else if (fin && !mem_ff) begin
                // (RULE19) ready on completion
                cmd_ff[CMD_READY_BIT] <= 1'b1;
            end
        end
    end

    // Data register: software writes, config/IO reads return here.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_ff <= 32'h0;
        end else if (xfer && !mem_ff && rd_ff) begin
            // (RULE20) read data returned
            data_ff <= in_s2_ff.ad;
        end else if (aph_wr_ff && reg_off(aph_addr_ff) == OFF_DATA) begin
            data_ff <= hwdata;
        end
    end

    // Sticky error status; write one clears, a new event wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_ff <= 32'h0;
        end else begin
            stat_ff[6:0] <= (stat_ff[6:0] & ~(stat_wr ? hwdata[6:0] : 7'h0))
                | err_set;
            stat_ff[ST_REFUSED] <= (stat_ff[ST_REFUSED] &&
                !(stat_wr && hwdata[ST_REFUSED])) ||
                (be_req && be_src == 2'h0 && st_ff == S_IDLE);
        end
    end

    // Write buffer filled by the back end before the request.
    // (RULE11) sixteen-word write buffer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr_ff <= 4'h0;
        end else if (mem_go) begin
            wptr_ff <= 4'h0;
        end else if (be_wpush) begin
            wptr_ff <= wptr_ff + 4'h1;
        end
    end

    always_ff @(posedge hclk) begin
        if (be_wpush && !mem_go) begin
            wbuf[wptr_ff] <= be_wdata;
        end
        if (xfer && mem_ff && rd_ff) begin
            // (RULE11) sixteen-word read buffer
            rbuf[idx_ff[3:0]] <= in_s2_ff.ad;
        end
        be_rdata <= rbuf[be_ridx];
    end

    // Link clock and pins pass two flops before use.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_s1_ff <= 1'b0;
            clk_s2_ff <= 1'b0;
            clk_s3_ff <= 1'b0;
            in_s1_ff <= '1;
            in_s2_ff <= '1;
        end else begin
            clk_s1_ff <= pci_clk;
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
            in_s1_ff <= pin_in;
            in_s2_ff <= in_s1_ff;
        end
    end

    assign pe = clk_s2_ff && !clk_s3_ff;
    // (RULE8) controller 0 refused
    assign mem_go = be_req && be_src != 2'h0 && st_ff == S_IDLE && !proxy_go;
    assign be_ack = mem_go;
    // (RULE17) stretch while target not ready
    assign xfer = pe && st_ff == S_DATA && !in_s2_ff.trdy_n
        && !in_s2_ff.devsel_n;
    assign last = idx_ff + 5'h1 == len_ff;
    assign fin = pe && st_ff == S_TURN;
    assign be_done = fin && mem_ff;

    // Bus exception detection during the data phase.
    // (RULE18) exception watch
    always_comb begin
        err_set = 7'h0;
        if (pe && st_ff == S_DATA) begin
            err_set[ST_MABORT] = !devsel_seen_ff && in_s2_ff.devsel_n
                && dcnt_ff == MABORT_EDGES;
            err_set[ST_TABORT] = !in_s2_ff.stop_n && in_s2_ff.devsel_n;
            err_set[ST_RETRY] = !in_s2_ff.stop_n && !in_s2_ff.devsel_n
                && in_s2_ff.trdy_n;
            err_set[ST_DISC] = !in_s2_ff.stop_n && !in_s2_ff.trdy_n
                && !last;
            err_set[ST_LAT] = !in_s2_ff.gnt_n ? 1'b0 : lat_ff == LAT_EDGES;
            err_set[ST_PERR] = !in_s2_ff.perr_n;
            err_set[ST_SERR] = !in_s2_ff.serr_n;
        end
    end

    // Command choice for proxy and memory transactions.
    function automatic logic [3:0] pick_cmd(input logic mem,
            input logic rd, input logic io, input logic [4:0] len);
        logic [4:0] cls;
        cls = ctrl_ff[CTRL_CLS_LSB +: 5];
        if (!mem) begin
            pick_cmd = io ? (rd ? PCMD_IO_RD : PCMD_IO_WR)
                : (rd ? PCMD_CFG_RD : PCMD_CFG_WR);
        end else if (!ctrl_ff[CTRL_AUTO_BIT] || len == 5'h1) begin
            // (RULE10) basic commands
            pick_cmd = rd ? PCMD_MEM_RD : PCMD_MEM_WR;
        end else if (rd) begin
            pick_cmd = len >= cls ? PCMD_MEM_RDM : PCMD_MEM_RDL;
        end else begin
            pick_cmd = len == cls ? PCMD_MEM_WRI : PCMD_MEM_WR;
        end
    endfunction

    // Transaction capture: address translation or proxy address.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_ff <= 1'b0;
            rd_ff <= 1'b0;
            len_ff <= 5'h1;
            paddr_ff <= 32'h0;
            pcmd_ff <= 4'h0;
        end else if (mem_go) begin
            mem_ff <= 1'b1;
            rd_ff <= !be_write;
            len_ff <= be_len == 5'h0 ? 5'h1 : be_len;
            pcmd_ff <= pick_cmd(1'b1, !be_write, 1'b0, be_len);
            // (RULE2) (RULE3) (RULE4) (RULE5) window translation
            paddr_ff <= {win_ff[be_addr[WSEL_LSB +: WSEL_W]],
                be_addr[UPPER_LSB-1:0]};
        end else if (proxy_go) begin
            mem_ff <= 1'b0;
            rd_ff <= hwdata[CMD_DIR_BIT];
            len_ff <= 5'h1;
            // (RULE12) low bits carry the type
            paddr_ff <= addr_ff;
            pcmd_ff <= pick_cmd(1'b0, hwdata[CMD_DIR_BIT],
                hwdata[CMD_TYPE_BIT], 5'h1);
        end
    end

    // PCI master sequencer, stepped on sampled link clock edges.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= S_IDLE;
        end else if (mem_go || proxy_go) begin
            st_ff <= S_REQ;
        end else if (pe) begin
            unique case (st_ff)
                S_IDLE: st_ff <= S_IDLE;
                S_REQ: begin
                    if (!in_s2_ff.gnt_n) begin
                        st_ff <= S_ADDR;
                    end
                end
                S_ADDR: st_ff <= S_DATA;
                S_DATA: begin
                    // (RULE22) every exit ends in ready
                    if ((xfer && last) || |err_set[4:0]) begin
                        st_ff <= S_TURN;
                    end
                end
                S_TURN: st_ff <= S_IDLE;
            endcase
        end
    end

    // Data phase counters and devsel tracking.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_ff <= 5'h0;
            dcnt_ff <= 4'h0;
            lat_ff <= 8'h0;
            devsel_seen_ff <= 1'b0;
        end else if (pe && st_ff == S_ADDR) begin
            idx_ff <= 5'h0;
            dcnt_ff <= 4'h1;
            lat_ff <= 8'h0;
            devsel_seen_ff <= 1'b0;
        end else if (pe && st_ff == S_DATA) begin
            if (xfer) begin
                idx_ff <= idx_ff + 5'h1;
            end
            if (dcnt_ff != MABORT_EDGES) begin
                dcnt_ff <= dcnt_ff + 4'h1;
            end
            if (lat_ff != LAT_EDGES) begin
                lat_ff <= lat_ff + 8'h1;
            end
            devsel_seen_ff <= devsel_seen_ff || !in_s2_ff.devsel_n;
        end
    end

    // Pin drive, registered; outputs change on the third clock edge after a link edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            po_ff <= '{req_n: 1'b1, frame_n: 1'b1, irdy_n: 1'b1,
                cbe_n: 4'hf, default: '0};
        end else if (pe) begin
            po_ff.req_n <= !(st_ff == S_REQ && in_s2_ff.gnt_n);
            if (st_ff == S_REQ && !in_s2_ff.gnt_n) begin
                // (RULE15) frame with address and command
                po_ff.frame_n <= 1'b0;
                po_ff.frame_oe <= 1'b1;
                po_ff.irdy_oe <= 1'b1;
                po_ff.ad <= paddr_ff;
                po_ff.ad_oe <= 1'b1;
                po_ff.cbe_n <= pcmd_ff;
                po_ff.cbe_oe <= 1'b1;
            end else if (st_ff == S_ADDR) begin
                // (RULE16) irdy, frame off, write data
                po_ff.irdy_n <= 1'b0;
                po_ff.frame_n <= len_ff == 5'h1;
                po_ff.ad <= mem_ff ? wbuf[0] : data_ff;
                po_ff.ad_oe <= !rd_ff;
                // (RULE13) byte enables, active low on pins
                po_ff.cbe_n <= mem_ff ? 4'h0 : ~cmd_ff[CMD_BE_LSB +: 4];
            end else if (st_ff == S_DATA) begin
                if ((xfer && last) || |err_set[4:0]) begin
                    po_ff.frame_n <= 1'b1;
                    po_ff.irdy_n <= 1'b1;
                    po_ff.ad_oe <= 1'b0;
                    po_ff.cbe_oe <= 1'b0;
                end else if (xfer) begin
                    po_ff.frame_n <= idx_ff + 5'h2 == len_ff;
                    po_ff.ad <= wbuf[idx_ff[3:0] + 4'h1];
                end
            end else if (st_ff == S_TURN) begin
                po_ff.frame_oe <= 1'b0;
                po_ff.irdy_oe <= 1'b0;
            end
        end
    end

    assign pin_out = po_ff;

    // (RULE21) ready stays clear while busy
    a_ready_busy: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff != S_IDLE && !mem_ff) |-> !cmd_ff[CMD_READY_BIT])
        else $error("ready set during proxy transaction");
    // (RULE19) ready follows proxy completion
    a_ready_done: assert property (@(posedge hclk) disable iff (!hresetn)
        (fin && !mem_ff) |=> cmd_ff[CMD_READY_BIT])
        else $error("ready not set after proxy end");
    // (RULE15) command code on frame
    a_cfg_wr_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(po_ff.frame_n) && !mem_ff && !rd_ff && !cmd_ff[CMD_TYPE_BIT]
        |-> po_ff.cbe_n == PCMD_CFG_WR)
        else $error("config write command wrong");
    // (RULE20) read command code
    a_cfg_rd_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(po_ff.frame_n) && !mem_ff && rd_ff && !cmd_ff[CMD_TYPE_BIT]
        |-> po_ff.cbe_n == PCMD_CFG_RD)
        else $error("config read command wrong");
    // (RULE16) single phase ends frame with irdy
    a_irdy_frame: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(po_ff.irdy_n) && !mem_ff |-> po_ff.frame_n)
        else $error("frame held with irdy on single phase");
    // (RULE5) translated address
    a_xlate_addr: assert property (@(posedge hclk) disable iff (!hresetn)
        mem_go |=> paddr_ff[22:0] == $past(be_addr[22:0]))
        else $error("low address bits not passed");
    // (RULE8) refused source starts nothing
    a_src_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
        be_req && be_src == 2'h0 |-> !be_ack)
        else $error("controller zero accepted");
    // (RULE17) irdy held until target ready
    a_no_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff == S_DATA && !po_ff.irdy_n && in_s2_ff.trdy_n
        && in_s2_ff.stop_n && !pe |=> !po_ff.irdy_n)
        else $error("irdy dropped while waiting");
    // (RULE7) reserved bits read zero
    a_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_wait_ff && $past(reg_off(aph_addr_ff)) < OFF_CMD
        |-> hrdata_ff[22:0] == 23'h0)
        else $error("reserved window bits not zero");

    c_cfg_write: cover property (@(posedge hclk) disable iff (!hresetn)
        fin && !mem_ff && !rd_ff);
    c_cfg_read: cover property (@(posedge hclk) disable iff (!hresetn)
        fin && !mem_ff && rd_ff);
    c_mem_burst: cover property (@(posedge hclk) disable iff (!hresetn)
        be_done && len_ff > 5'h1);
    c_mabort: cover property (@(posedge hclk) disable iff (!hresetn)
        err_set[ST_MABORT]);
endmodule
`default_nettype wire

// ===== verilog/pcimw_pkg.sv
// Package of constants and pin bundles for the PCI master window bridge.
package pcimw_pkg;
    localparam logic [11:0] OFF_WIN0 = 12'h000;
    localparam logic [11:0] OFF_CMD = 12'h100;
    localparam logic [11:0] OFF_DATA = 12'h104;
    localparam logic [11:0] OFF_ADDR = 12'h108;
    localparam logic [11:0] OFF_CTRL = 12'h10c;
    localparam logic [11:0] OFF_STAT = 12'h110;
    localparam int WIN_NUM = 32;
    localparam int UPPER_LSB = 23;
    localparam int UPPER_W = 9;
    localparam int WSEL_LSB = 23;
    localparam int WSEL_W = 5;
    localparam int CMD_READY_BIT = 31;
    localparam int CMD_DIR_BIT = 0;
    localparam int CMD_TYPE_BIT = 1;
    localparam int CMD_BE_LSB = 4;
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_CLS_LSB = 8;
    localparam int BUF_DEPTH = 16;
    localparam logic [3:0] MABORT_EDGES = 4'h5;
    localparam logic [7:0] LAT_EDGES = 8'h20;
    localparam logic [31:0] CMD_RESET = 32'h8000_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_1000;
    localparam logic [3:0] PCMD_CFG_RD = 4'ha;
    localparam logic [3:0] PCMD_CFG_WR = 4'hb;
    localparam logic [3:0] PCMD_IO_RD = 4'h2;
    localparam logic [3:0] PCMD_IO_WR = 4'h3;
    localparam logic [3:0] PCMD_MEM_RD = 4'h6;
    localparam logic [3:0] PCMD_MEM_WR = 4'h7;
    localparam logic [3:0] PCMD_MEM_RDM = 4'hc;
    localparam logic [3:0] PCMD_MEM_RDL = 4'he;
    localparam logic [3:0] PCMD_MEM_WRI = 4'hf;
    // Status bit positions, all sticky.
    localparam int ST_MABORT = 0;
    localparam int ST_TABORT = 1;
    localparam int ST_RETRY = 2;
    localparam int ST_DISC = 3;
    localparam int ST_LAT = 4;
    localparam int ST_PERR = 5;
    localparam int ST_SERR = 6;
    localparam int ST_REFUSED = 7;
    typedef struct packed {
        logic gnt_n;
        logic trdy_n;
        logic stop_n;
        logic devsel_n;
        logic perr_n;
        logic serr_n;
        logic [31:0] ad;
    } pcimw_pin_in_type;
    typedef struct packed {
        logic req_n;
        logic frame_n;
        logic frame_oe;
        logic irdy_n;
        logic irdy_oe;
        logic [31:0] ad;
        logic ad_oe;
        logic [3:0] cbe_n;
        logic cbe_oe;
    } pcimw_pin_out_type;
endpackage
